// ===== logic/info_row_dtr_cmd.sv
/*
  Command logic for the security information rows (program and read) and the
  double-rate main-array read, in single-line and four-line protocol.
  Assumes the host drives csN, sck and the io lanes; sck stands still while
  csN is high. Configuration inputs are quasi-static on the system clock.
*/
// Notes on behaviour
// - Program opcode writes one to 256 bytes into the chosen information row.
// - Program starts only at chip-select rise after whole bytes; otherwise discarded.
// - During programming every command except status read is ignored.
// - In-progress flag reads one while programming, zero once finished.
// - Over 256 bytes the pointer wraps in the page; last 256 kept.
// - Bytes of the page that were not addressed stay unchanged.
// - Programming only clears bits; ones return only by row erase.
// - Info read opcode, address and dummies sampled on rising sck edges.
// - Info read data driven on falling edges, starting at the given address.
// - Read address increments per byte; past row end contents are meaningless.
// - Info read while a cycle runs is ignored without effect.
// - Double-rate opcode takes three or four address bytes; wide opcode four.
// - Single-line: opcode one bit per clock, address and data on both edges.
// - Double-rate read address increments per byte and rolls over to zero.
// - Chip-select rise during data output stops the device driving.
// - Single-line double-rate read during a busy cycle is rejected.
// - Four-line: opcode in two clocks, eight bits per clock, six dummies default.
// - No opcode-skipping continuous read for these opcodes in four-line mode.
// - Four-line double-rate read during a busy cycle is rejected.
// - A row whose lock bit is one is read-only and never programmed.
`timescale 1ns/10ps
`default_nettype none

module info_row_dtr_cmd #(
  parameter int MAIN_AW = 12,
  parameter int PROG_CYCLES = info_row_pkg::PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sck,
  input wire logic csN,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic fourLineProtocol,
  input wire logic extendedAddressSetting,
  input wire logic [3:0] dummyCfg,
  input wire logic [3:0] rowLockBit,
  input wire logic extBusy,
  input wire logic mainWrEn,
  input wire logic [MAIN_AW-1:0] mainWrAddr,
  input wire logic [7:0] mainWrData,
  output logic inProgressFlag,
  output logic writePermitLatch
);

  localparam int CW = MAIN_AW + 4;
  localparam int INFO_BYTES = info_row_pkg::PAGE_BYTES * info_row_pkg::INFO_ROWS;

  // ****************************************
  // Storage
  // ****************************************
  // The row and main arrays are written on mclk and read from the sck side. Reads are only
  // accepted while nothing is in progress, so the words they see are stable.
  logic [7:0] infoMem [INFO_BYTES];
  logic [7:0] mainMem [2**MAIN_AW];
  logic [7:0] pageBuf [info_row_pkg::PAGE_BYTES];
  logic [info_row_pkg::PAGE_BYTES-1:0] pageMask_reg;
  logic [7:0] pagePtr_reg;
  logic [1:0] row_reg;
  info_row_pkg::frame_cmd_e frameCmd_reg;

  // ****************************************
  // Link side: synchronisers
  // ****************************************
  logic [1:0] busyS_reg;
  logic [1:0] permitS_reg;
  logic [1:0] qpiS_reg;
  logic [1:0] extS_reg;
  logic linkBusy;
  logic linkQpi;

  always_ff @(posedge sck) begin
    busyS_reg <= {busyS_reg[0], inProgressFlag};
    permitS_reg <= {permitS_reg[0], writePermitLatch};
    qpiS_reg <= {qpiS_reg[0], fourLineProtocol};
    extS_reg <= {extS_reg[0], extendedAddressSetting};
  end

  assign linkBusy = busyS_reg[1];
  assign linkQpi = qpiS_reg[1];

  // ****************************************
  // Link side: command sequencer
  // ****************************************
  info_row_pkg::phase_e phase_reg;
  info_row_pkg::src_e src_reg;
  logic [5:0] clkCnt_reg;
  logic [5:0] addrClocks_reg;
  logic [3:0] dummyN_reg;
  logic [7:0] opSh_reg;
  logic [7:0] wrSh_reg;
  logic [31:0] addrSh_reg;
  logic [31:0] base_reg;
  logic [3:0] riseHeld_reg;
  logic [3:0] fallIn_reg;
  logic pairPend_reg;
  logic dtr_reg;
  logic isWrite_reg;
  logic dataOn_reg;

  function automatic logic [31:0] shiftLanes(input logic [31:0] sh, input logic quad,
                                             input logic [3:0] v);
    shiftLanes = quad ? {sh[27:0], v} : {sh[30:0], v[0]};
  endfunction : shiftLanes

  logic [7:0] opNow;
  logic [7:0] wrNow;
  logic [31:0] sdrAddr;
  logic [31:0] pairAddr;
  logic [31:0] addrNow;
  logic [2:0] lastSlot;
  logic opDone;
  logic addrDone;
  logic byteDone;
  logic progAccept;
  logic wideAddr;
  logic [3:0] dummyPick;

  assign lastSlot = linkQpi ? 3'h1 : 3'h7;
  assign opNow = linkQpi ? {opSh_reg[3:0], ioIn} : {opSh_reg[6:0], ioIn[0]};
  assign wrNow = linkQpi ? {wrSh_reg[3:0], ioIn} : {wrSh_reg[6:0], ioIn[0]};
  assign opDone = (phase_reg == info_row_pkg::PH_OPCODE) && (clkCnt_reg == {3'h0, lastSlot});
  assign addrDone = (phase_reg == info_row_pkg::PH_ADDR) && (clkCnt_reg == addrClocks_reg - 6'h1);
  assign byteDone = (phase_reg == info_row_pkg::PH_WRITE) && (clkCnt_reg == {3'h0, lastSlot});
  assign progAccept = opDone && (opNow == info_row_pkg::OP_INFO_PROGRAM) && !linkBusy;
  assign sdrAddr = shiftLanes(addrSh_reg, linkQpi, ioIn);
  assign pairAddr = shiftLanes(shiftLanes(addrSh_reg, linkQpi, riseHeld_reg), linkQpi, fallIn_reg);
  assign addrNow = pairPend_reg ? pairAddr : addrSh_reg;
  assign wideAddr = (opNow == info_row_pkg::OP_DTR_READ_WIDE) || extS_reg[1];
  assign dummyPick = (dummyCfg != 4'h0) ? dummyCfg :
                     (linkQpi ? info_row_pkg::DUMMY_DEF_FOUR : info_row_pkg::DUMMY_DEF_SINGLE);

  // Falling-edge samples pair up with the rising sample of the same clock.
  always_ff @(negedge sck) begin
    fallIn_reg <= ioIn;
  end

  // Frame state clears whenever chip select is high, so each frame starts clean.
  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      phase_reg <= info_row_pkg::PH_OPCODE;
      src_reg <= info_row_pkg::SRC_STATUS;
      clkCnt_reg <= 6'h0;
      addrClocks_reg <= 6'h0;
      dummyN_reg <= 4'h0;
      opSh_reg <= 8'h0;
      wrSh_reg <= 8'h0;
      addrSh_reg <= 32'h0;
      base_reg <= 32'h0;
      riseHeld_reg <= 4'h0;
      pairPend_reg <= 1'b0;
      dtr_reg <= 1'b0;
      isWrite_reg <= 1'b0;
      dataOn_reg <= 1'b0;
    end else begin
      riseHeld_reg <= ioIn;
      case (phase_reg)
        info_row_pkg::PH_OPCODE: begin
          opSh_reg <= opNow;
          clkCnt_reg <= clkCnt_reg + 6'h1;
          if (opDone) begin
            clkCnt_reg <= 6'h0;
            dummyN_reg <= dummyPick;
            phase_reg <= info_row_pkg::PH_IGNORE;
            case (opNow)
              info_row_pkg::OP_STATUS_READ: begin
                src_reg <= info_row_pkg::SRC_STATUS;
                phase_reg <= info_row_pkg::PH_DATA;
                dataOn_reg <= 1'b1;
              end
              info_row_pkg::OP_INFO_PROGRAM: begin
                if (!linkBusy) begin
                  isWrite_reg <= 1'b1;
                  addrClocks_reg <= info_row_pkg::ADDR_BITS_SHORT >> (linkQpi ? 2 : 0);
                  phase_reg <= info_row_pkg::PH_ADDR;
                end
              end
              info_row_pkg::OP_INFO_READ: begin
                if (!linkBusy) begin
                  src_reg <= info_row_pkg::SRC_INFO;
                  addrClocks_reg <= info_row_pkg::ADDR_BITS_SHORT >> (linkQpi ? 2 : 0);
                  phase_reg <= info_row_pkg::PH_ADDR;
                end
              end
              info_row_pkg::OP_DTR_READ, info_row_pkg::OP_DTR_READ_WIDE: begin
                // Mode bits in the dummy phase are never decoded here.
                if (!linkBusy) begin
                  src_reg <= info_row_pkg::SRC_MAIN;
                  dtr_reg <= 1'b1;
                  addrClocks_reg <= (wideAddr ? info_row_pkg::ADDR_BITS_LONG :
                                     info_row_pkg::ADDR_BITS_SHORT) >> (linkQpi ? 3 : 1);
                  phase_reg <= info_row_pkg::PH_ADDR;
                end
              end
              default: begin
                phase_reg <= info_row_pkg::PH_IGNORE;
              end
            endcase
          end
        end
        info_row_pkg::PH_ADDR: begin
          clkCnt_reg <= clkCnt_reg + 6'h1;
          if (dtr_reg) begin
            // A clock's two samples are complete only at the next rising edge.
            if (pairPend_reg) begin
              addrSh_reg <= pairAddr;
            end
            pairPend_reg <= 1'b1;
          end else begin
            addrSh_reg <= sdrAddr;
          end
          if (addrDone) begin
            clkCnt_reg <= 6'h0;
            phase_reg <= isWrite_reg ? info_row_pkg::PH_WRITE : info_row_pkg::PH_DUMMY;
          end
        end
        info_row_pkg::PH_DUMMY: begin
          clkCnt_reg <= clkCnt_reg + 6'h1;
          if (pairPend_reg) begin
            addrSh_reg <= pairAddr;
            pairPend_reg <= 1'b0;
          end
          if (clkCnt_reg == {2'h0, dummyN_reg} - 6'h1) begin
            base_reg <= addrNow;
            dataOn_reg <= 1'b1;
            phase_reg <= info_row_pkg::PH_DATA;
          end
        end
        info_row_pkg::PH_WRITE: begin
          wrSh_reg <= wrNow;
          clkCnt_reg <= byteDone ? 6'h0 : clkCnt_reg + 6'h1;
        end
        info_row_pkg::PH_DATA: begin
          phase_reg <= info_row_pkg::PH_DATA;
        end
        default: begin
          phase_reg <= info_row_pkg::PH_IGNORE;
        end
      endcase
    end
  end

  // ****************************************
  // Link side: hand-over of a finished command
  // ****************************************
  // Not cleared by chip select: the system side reads these after the rise.
  always_ff @(posedge sck) begin
    if ((phase_reg == info_row_pkg::PH_OPCODE) && (clkCnt_reg == 6'h0)) begin
      frameCmd_reg <= info_row_pkg::CMD_NONE;
    end else if (opDone && (opNow == info_row_pkg::OP_WRITE_PERMIT) && !linkBusy) begin
      frameCmd_reg <= info_row_pkg::CMD_PERMIT;
    end else if ((phase_reg == info_row_pkg::PH_WRITE) && (clkCnt_reg == 6'h0)) begin
      frameCmd_reg <= info_row_pkg::CMD_NONE;
    end else if (byteDone) begin
      frameCmd_reg <= info_row_pkg::CMD_PROGRAM;
    end
  end

  always_ff @(posedge sck) begin
    if (progAccept) begin
      pageMask_reg <= '0;
    end
    if (addrDone && isWrite_reg) begin
      pagePtr_reg <= sdrAddr[7:0];
      row_reg <= sdrAddr[info_row_pkg::ROW_LSB+1:info_row_pkg::ROW_LSB];
    end
    if (byteDone) begin
      pageBuf[pagePtr_reg] <= wrNow;
      pageMask_reg[pagePtr_reg] <= 1'b1;
      pagePtr_reg <= pagePtr_reg + 8'h1;
    end
  end

  // ****************************************
  // Link side: data output
  // ****************************************
  logic [CW-1:0] fallCnt_reg;
  logic [CW-1:0] riseCnt_reg;
  logic [3:0] fallOut_reg;
  logic [3:0] riseOut_reg;
  logic oe_reg;
  logic [7:0] statusByte;

  always_comb begin
    statusByte = 8'h00;
    statusByte[info_row_pkg::STAT_BIT_BUSY] = busyS_reg[1];
    statusByte[info_row_pkg::STAT_BIT_PERMIT] = permitS_reg[1];
  end

  function automatic logic [7:0] fetchByte(input logic [CW-1:0] slot);
    logic [CW-1:0] idx;
    logic [9:0] infoA;
    logic [MAIN_AW-1:0] mainA;
    idx = linkQpi ? (slot >> 1) : (slot >> 3);
    // Past a row end the index runs into the next row: content is meaningless.
    infoA = {base_reg[info_row_pkg::ROW_LSB+1:info_row_pkg::ROW_LSB], base_reg[7:0]} + idx[9:0];
    mainA = base_reg[MAIN_AW-1:0] + idx[MAIN_AW-1:0];
    case (src_reg)
      info_row_pkg::SRC_INFO: fetchByte = infoMem[infoA];
      info_row_pkg::SRC_MAIN: fetchByte = mainMem[mainA];
      default: fetchByte = statusByte;
    endcase
  endfunction : fetchByte

  function automatic logic [3:0] laneBits(input logic [CW-1:0] slot);
    logic [7:0] b;
    b = fetchByte(slot);
    if (linkQpi) begin
      laneBits = slot[0] ? b[3:0] : b[7:4];
    end else begin
      laneBits = {2'b00, b[3'h7 - slot[2:0]], 1'b0};
    end
  endfunction : laneBits

  always_ff @(negedge sck or posedge csN) begin
    if (csN) begin
      fallCnt_reg <= '0;
      fallOut_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (dataOn_reg) begin
      fallOut_reg <= laneBits(dtr_reg ? {fallCnt_reg[CW-2:0], 1'b0} : fallCnt_reg);
      fallCnt_reg <= fallCnt_reg + 1'b1;
      oe_reg <= 1'b1;
    end
  end

  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      riseCnt_reg <= '0;
      riseOut_reg <= 4'h0;
    end else if (dataOn_reg && dtr_reg) begin
      riseOut_reg <= laneBits({riseCnt_reg[CW-2:0], 1'b1});
      riseCnt_reg <= riseCnt_reg + 1'b1;
    end
  end

  // Double-rate output cell: the half-period after each edge shows the value
  // launched at that edge. The clock-level select is the usual trade for DDR.
  assign ioOut = (dtr_reg && sck) ? riseOut_reg : fallOut_reg;
  assign ioOe = oe_reg ? (linkQpi ? 4'hF : 4'h2) : 4'h0;

  // ****************************************
  // System side: frame end and programming
  // ****************************************
  logic [2:0] csS_reg;
  logic frameEnd;
  info_row_pkg::prog_state_e progState_reg;
  logic [7:0] copyIdx_reg;
  logic [15:0] waitCnt_reg;
  logic permit_reg;
  logic busy_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      csS_reg <= 3'h7;
    end else begin
      csS_reg <= {csS_reg[1:0], csN};
    end
  end

  assign frameEnd = csS_reg[1] && !csS_reg[2];

  always_ff @(posedge mclk) begin
    if (rst) begin
      progState_reg <= info_row_pkg::PG_IDLE;
      copyIdx_reg <= 8'h0;
      waitCnt_reg <= 16'h0;
      permit_reg <= 1'b0;
    end else begin
      case (progState_reg)
        info_row_pkg::PG_IDLE: begin
          if (frameEnd && !extBusy) begin
            if (frameCmd_reg == info_row_pkg::CMD_PERMIT) begin
              permit_reg <= 1'b1;
            end else if ((frameCmd_reg == info_row_pkg::CMD_PROGRAM) && permit_reg &&
                         !rowLockBit[row_reg]) begin
              copyIdx_reg <= 8'h0;
              progState_reg <= info_row_pkg::PG_COPY;
            end
          end
        end
        info_row_pkg::PG_COPY: begin
          copyIdx_reg <= copyIdx_reg + 8'h1;
          if (copyIdx_reg == 8'hFF) begin
            waitCnt_reg <= 16'h0;
            progState_reg <= info_row_pkg::PG_WAIT;
          end
        end
        info_row_pkg::PG_WAIT: begin
          waitCnt_reg <= waitCnt_reg + 16'h1;
          if (waitCnt_reg == 16'(PROG_CYCLES - 1)) begin
            permit_reg <= 1'b0;
            progState_reg <= info_row_pkg::PG_IDLE;
          end
        end
        default: begin
          progState_reg <= info_row_pkg::PG_IDLE;
        end
      endcase
    end
  end

  // The page buffer is stable here: no new program is accepted while busy.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < INFO_BYTES; i++) begin
        infoMem[i] <= info_row_pkg::ERASED_BYTE;
      end
    end else if ((progState_reg == info_row_pkg::PG_COPY) && pageMask_reg[copyIdx_reg]) begin
      infoMem[{row_reg, copyIdx_reg}] <= infoMem[{row_reg, copyIdx_reg}] & pageBuf[copyIdx_reg];
    end
  end

  always_ff @(posedge mclk) begin
    if (mainWrEn) begin
      mainMem[mainWrAddr] <= mainWrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= extBusy || (progState_reg != info_row_pkg::PG_IDLE);
    end
  end

  assign inProgressFlag = busy_reg;
  assign writePermitLatch = permit_reg;

endmodule : info_row_dtr_cmd

`default_nettype wire

// ===== logic/info_row_pkg.sv
/*
  Constants shared by the information-row and double-rate read command block:
  opcodes, field positions, defaults, timing and the state and mode types.
  Assumes a 50 MHz system clock; all users refer to names here by full scope.
*/
package info_row_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OP_INFO_PROGRAM = 8'h62;
  localparam logic [7:0] OP_INFO_READ = 8'h68;
  localparam logic [7:0] OP_DTR_READ = 8'h0D;
  localparam logic [7:0] OP_DTR_READ_WIDE = 8'h0E;

  // ****************************************
  // Geometry and field positions
  // ****************************************
  localparam int PAGE_BYTES = 256;
  localparam int INFO_ROWS = 4;
  localparam int ROW_LSB = 12;
  localparam int STAT_BIT_BUSY = 0;
  localparam int STAT_BIT_PERMIT = 1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] DUMMY_DEF_SINGLE = 4'h8;
  localparam logic [3:0] DUMMY_DEF_FOUR = 4'h6;
  localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
  localparam logic [5:0] ADDR_BITS_LONG = 6'h20;

  // ****************************************
  // Timing
  // ****************************************
  localparam int MCLK_HZ = 50_000_000;
  localparam int PROG_TIME_NS = 2000;
  localparam int PROG_CYCLES = (PROG_TIME_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PH_OPCODE = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b011,
    PH_DATA = 3'b111,
    PH_WRITE = 3'b101,
    PH_IGNORE = 3'b100
  } phase_e;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_PERMIT = 2'b01,
    CMD_PROGRAM = 2'b11
  } frame_cmd_e;

  typedef enum logic [1:0] {
    SRC_STATUS = 2'b00,
    SRC_INFO = 2'b01,
    SRC_MAIN = 2'b11
  } src_e;

  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_COPY = 2'b01,
    PG_WAIT = 2'b11
  } prog_state_e;

endpackage : info_row_pkg

// ===== verif/info_row_props.sv
/*
  Checker for the information-row command block, bound to its top module.
  Assumes extBusy stays low while a program runs and csN gaps of many mclk cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module info_row_props #(
  parameter int PROG_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic csN,
  input wire logic [3:0] ioOe,
  input wire logic fourLineProtocol,
  input wire logic extBusy,
  input wire logic inProgressFlag,
  input wire logic writePermitLatch
);
  // ****************
  // Busy length count
  // ****************
  logic [15:0] busyCnt_reg;
  logic extSeen_reg;
  always_ff @(posedge mclk) begin
    if (rst || !inProgressFlag) begin
      busyCnt_reg <= 16'h0000;
      extSeen_reg <= 1'b0;
    end else begin
      busyCnt_reg <= busyCnt_reg + 16'h0001;
      extSeen_reg <= extSeen_reg | extBusy;
    end
  end
  a_reset_clears: assert property (@(posedge mclk) disable iff (rst) // RESET
    $past(rst) |-> !inProgressFlag && !writePermitLatch) else $error("flags not cleared");
  a_ext_busy_flag: assert property (@(posedge mclk) disable iff (rst)
    extBusy |-> ##[1:3] inProgressFlag) else $error("busy flag missing");
  a_prog_after_cs: assert property (@(posedge mclk) disable iff (rst)
    $rose(inProgressFlag) && !extBusy && !$past(extBusy) |-> csN) else $error("early start");
  a_prog_busy_len: assert property (@(posedge mclk) disable iff (rst)
    $fell(inProgressFlag) && !extSeen_reg |-> busyCnt_reg == 16'(256 + PROG_CYCLES))
    else $error("program length wrong");
  a_permit_clear: assert property (@(posedge mclk) disable iff (rst)
    $fell(writePermitLatch) && !extBusy |-> ##[0:2] !inProgressFlag) else $error("latch drop");
  a_permit_at_end: assert property (@(posedge mclk) disable iff (rst)
    $rose(writePermitLatch) |-> csN && !inProgressFlag) else $error("latch set mid frame");
  a_cs_high_quiet: assert property (@(posedge mclk) disable iff (rst)
    csN |-> ioOe == 4'h0) else $error("lanes driven while deselected");
  a_single_lane_oe: assert property (@(posedge mclk) disable iff (rst)
    !fourLineProtocol && ioOe != 4'h0 |-> ioOe == 4'h2) else $error("wrong lane driven");
endmodule : info_row_props
bind info_row_dtr_cmd info_row_props #(.PROG_CYCLES(PROG_CYCLES)) u_info_row_props (
  .mclk(mclk), .rst(rst), .csN(csN), .ioOe(ioOe), .fourLineProtocol(fourLineProtocol),
  .extBusy(extBusy), .inProgressFlag(inProgressFlag), .writePermitLatch(writePermitLatch));
`default_nettype wire

// ===== verif/flash_host_model.sv
/*
  Host controller model: drives csN, sck and the lanes in single-line mode and
  captures read bytes from lane 1. Assumes mode 0 and an 80 ns stopped clock.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
  output logic sck,
  output logic csN,
  output logic [3:0] hostOut,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  output logic [7:0] rxData,
  output logic sawOe
);
  event got;
  logic [7:0] sh;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    hostOut = 4'h0;
    rxData = 8'h00;
    sawOe = 1'b0;
    sh = 8'h00;
  end
  // ****************
  // Lanes change a quarter period before each edge, so both edges see settled data.
  // ****************
  task automatic tick(input logic d);
    hostOut = {~hostOut[3:1], d};
    #20;
    sck = ~sck;
    #20;
    if (ioOe !== 4'h0) sawOe = 1'b1;
  endtask : tick
  task automatic frame(input logic [7:0] op, input int na, input logic [31:0] a,
      input logic dtr, input int nd, input logic [7:0] wr[$], input int n);
    sawOe = 1'b0;
    csN = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tick(op[i]);
      tick(op[i]);
    end
    for (int i = na * 8 - 1; i >= 0; i--) begin
      tick(a[i]);
      if (!dtr) tick(a[i]);
    end
    for (int i = 0; i < 2 * nd; i++) tick(~hostOut[0]);
    foreach (wr[j]) begin
      for (int i = 7; i >= 0; i--) begin
        tick(wr[j][i]);
        tick(wr[j][i]);
      end
    end
    for (int i = 0; i < n * 8; i++) begin
      if (i > 0) tick(~hostOut[0]);
      if (i > 0 && !dtr) tick(~hostOut[0]);
      sh = {sh[6:0], ioOut[1]};
      if (i % 8 == 7 && sawOe) begin
        rxData = sh;
        -> got;
      end
    end
    if (sck) tick(~hostOut[0]);
    csN = 1'b1;
    #400;
  endtask : frame
endmodule : flash_host_model
`default_nettype wire

// ===== verif/info_row_dtr_cmd_tb.sv
/*
  Self-checking bench for the information-row and double-rate read block.
  Assumes the host model drives the link; expected bytes queue up for a monitor.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module info_row_dtr_cmd_tb;
  logic mclk, rst, sck, csN, fourLineProtocol, extendedAddressSetting, extBusy, mainWrEn;
  logic sawOe, inProgressFlag, writePermitLatch;
  logic [3:0] ioIn, ioOut, ioOe, hostOut, dummyCfg, rowLockBit;
  logic [11:0] mainWrAddr;
  logic [7:0] mainWrData, rxData, exp8;
  logic [7:0] info[1024];
  logic [7:0] mainRef[4096];
  logic [7:0] expQ[$];
  logic [7:0] wq[$];
  logic [31:0] seed;
  int err_total, checked;
  assign ioIn = (ioOe & ioOut) | (~ioOe & hostOut);
  info_row_dtr_cmd #(.MAIN_AW(12), .PROG_CYCLES(4)) u_info_row_dtr_cmd (
    .mclk(mclk), .rst(rst), .sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .fourLineProtocol(fourLineProtocol), .extendedAddressSetting(extendedAddressSetting),
    .dummyCfg(dummyCfg), .rowLockBit(rowLockBit), .extBusy(extBusy), .mainWrEn(mainWrEn),
    .mainWrAddr(mainWrAddr), .mainWrData(mainWrData), .inProgressFlag(inProgressFlag),
    .writePermitLatch(writePermitLatch));
  flash_host_model u_flash_host_model (.sck(sck), .csN(csN), .hostOut(hostOut),
    .ioOut(ioOut), .ioOe(ioOe), .rxData(rxData), .sawOe(sawOe));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  always @(u_flash_host_model.got) begin
    exp8 = (expQ.size() > 0) ? expQ.pop_front() : 8'hXX;
    `CHK(rxData, exp8)
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic stat(input logic [7:0] e);
    expQ.push_back(e);
    u_flash_host_model.frame(info_row_pkg::OP_STATUS_READ, 0, 0, 1'b0, 0, wq, 1);
  endtask : stat
  task automatic wen();
    u_flash_host_model.frame(info_row_pkg::OP_WRITE_PERMIT, 0, 0, 1'b0, 0, wq, 0);
    stat(8'h02);
  endtask : wen
  task automatic rd(input logic [7:0] op, input int na, input logic [31:0] a, input int nd,
      input int n);
    for (int i = 0; i < n; i++) begin
      if (op == info_row_pkg::OP_INFO_READ) expQ.push_back(info[{a[13:12], a[7:0]} + 10'(i)]);
      else expQ.push_back(mainRef[a[11:0] + 12'(i)]);
    end
    u_flash_host_model.frame(op, na, a, op != info_row_pkg::OP_INFO_READ, nd, wq, n);
  endtask : rd
  task automatic rej(input logic [7:0] op);
    u_flash_host_model.frame(op, 3, 32'h0, op != info_row_pkg::OP_INFO_READ, 8, wq, 1);
    `CHK(sawOe, 1'b0)
  endtask : rej
  task automatic prog(input logic [31:0] a, input int n, input logic ok);
    wq.delete();
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      wq.push_back(seed[7:0]);
    end
    for (int i = (n > 256) ? n - 256 : 0; i < n; i++) begin
      if (ok) info[{a[13:12], a[7:0] + 8'(i)}] &= wq[i];
    end
    u_flash_host_model.frame(info_row_pkg::OP_INFO_PROGRAM, 3, a, 1'b0, 0, wq, 0);
    wq.delete();
    `CHK(inProgressFlag, ok)
    if (ok) begin
      stat(8'h03);
      rej(info_row_pkg::OP_INFO_READ);
      for (int k = 0; k < 2000 && inProgressFlag !== 1'b0; k++) @(posedge mclk);
      `CHK(inProgressFlag, 1'b0)
      if (inProgressFlag !== 1'b0) end_sim();
      `CHK(writePermitLatch, 1'b0)
    end
  endtask : prog
  initial begin
    seed = 32'hF830;
    err_total = 0;
    checked = 0;
    rst = 1'b1;
    fourLineProtocol = 1'b0;
    extendedAddressSetting = 1'b0;
    extBusy = 1'b0;
    mainWrEn = 1'b0;
    mainWrAddr = 12'h000;
    mainWrData = 8'h00;
    dummyCfg = 4'h0;
    rowLockBit = 4'h0;
    for (int i = 0; i < 1024; i++) info[i] = 8'hFF;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(inProgressFlag, 1'b0) // RESET
    `CHK(writePermitLatch, 1'b0) // RESET
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      @(posedge mclk);
      mainWrEn <= 1'b1;
      mainWrAddr <= 12'hFF8 + 12'(i);
      mainWrData <= seed[7:0];
      mainRef[12'hFF8 + 12'(i)] = seed[7:0];
    end
    @(posedge mclk);
    mainWrEn <= 1'b0;
    // The link synchronisers run on sck only, so one ignored frame fills them first.
    u_flash_host_model.frame(8'h00, 0, 0, 1'b0, 0, wq, 0);
    stat(8'h00);
    rd(info_row_pkg::OP_INFO_READ, 3, 32'h0, 8, 4);
    prog(32'h1000, 4, 1'b0);
    wen();
    prog(32'h10FE, 258, 1'b1);
    rd(info_row_pkg::OP_INFO_READ, 3, 32'h10FC, 8, 8);
    wen();
    prog(32'h10FF, 3, 1'b1);
    rd(info_row_pkg::OP_INFO_READ, 3, 32'h10FD, 8, 6);
    rd(info_row_pkg::OP_DTR_READ, 3, 32'h000FFE, 8, 4);
    @(posedge mclk);
    extendedAddressSetting <= 1'b1;
    dummyCfg <= 4'h4;
    stat(8'h00);
    rd(info_row_pkg::OP_DTR_READ, 4, 32'h00000FFC, 4, 4);
    rd(info_row_pkg::OP_DTR_READ_WIDE, 4, 32'h2, 4, 3);
    @(posedge mclk);
    dummyCfg <= 4'h0;
    extBusy <= 1'b1;
    stat(8'h01);
    rej(info_row_pkg::OP_INFO_READ);
    rej(info_row_pkg::OP_DTR_READ);
    rej(info_row_pkg::OP_WRITE_PERMIT);
    @(posedge mclk);
    extBusy <= 1'b0;
    stat(8'h00);
    @(posedge mclk);
    rowLockBit <= 4'h4;
    wen();
    prog(32'h2000, 4, 1'b0);
    stat(8'h02);
    rd(info_row_pkg::OP_INFO_READ, 3, 32'h2000, 8, 4);
    end_sim();
  end
endmodule : info_row_dtr_cmd_tb
`default_nettype wire
